// ---- audio_out_pkg.sv ----
// constants, register map and types of the audio output status logic
// assumes a single 50 MHz processor clock; offsets are byte addresses
package audio_out_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] TIMESTAMP_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] BASE1_OFFSET = 8'h0C;
  localparam logic [7:0] BASE2_OFFSET = 8'h10;
  localparam logic [7:0] SIZE_OFFSET = 8'h14;

  // ==========================================================
  // control field positions
  localparam int CTL_RESET_BIT = 31;
  localparam int CTL_TRANS_BIT = 30;
  localparam int CTL_AWAKE_BIT = 29;
  localparam int CTL_INTEN_LSB = 4;
  localparam int CTL_ACK_LSB = 0;

  // flag order, shared by enables, acknowledges and status
  localparam int FLAG_FIRST = 0;
  localparam int FLAG_SECOND = 1;
  localparam int FLAG_BANDWIDTH = 2;
  localparam int FLAG_STARVED = 3;
  localparam int STATUS_ACTIVE_BIT = 4;

  localparam int IRQ_SOURCE_NUMBER = 12;

  // ==========================================================
  // reset values
  localparam logic [3:0] INTEN_RESET = 4'h0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [1:0] BUF_VALID_RESET = 2'h3;
  localparam logic [31:0] TIMESTAMP_RESET = 32'h0;
  localparam logic [31:0] BASE_RESET = 32'h0;
  localparam logic [15:0] SIZE_RESET = 16'h0;

  // ==========================================================
  // sizes and timing
  localparam int PREFETCH_BYTES = 64;
  localparam int WORD_BYTES = 4;
  localparam int PREFETCH_WORDS = PREFETCH_BYTES / WORD_BYTES;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ARB_MARGIN_NS = 20;
  localparam int ARB_MARGIN_CYCLES = (ARB_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {FETCH_IDLE, FETCH_WAIT} fetch_state_t;

endpackage

// ---- audio_out_prefetch.sv ----
// prefetch store for fetched sample words, first in first out
// assumes the writer never pushes while in_ready is low
`timescale 1ns/1ps
`default_nettype none
module audio_out_prefetch #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("prefetch depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [CW-1:0] count_ff, nxt_count;
  logic push, pop;

  assign in_ready = count_ff != CW'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data = mem[rd_ptr_ff];
  assign level = count_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr_ptr = push ? wr_ptr_ff + PW'(1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + PW'(1) : rd_ptr_ff;
    nxt_count = count_ff + CW'(push) - CW'(pop);
    if (flush) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule // audio_out_prefetch
`default_nettype wire

// ---- audio_out_irq_error_timestamp.sv ----
// status flags, interrupt, starvation recovery, timestamp and powerdown of the audio output
// assumes synchronous inputs, a plain register port and a word-wide memory read port
// What this block does
// - one interrupt line: any flag with enable
// - flags stay set until acknowledged
// - first acknowledge clears first drained, reads zero
// - second acknowledge clears second drained, reads zero
// - only bandwidth acknowledge clears bandwidth error
// - starved acknowledge alone clears underrun flag
// - transmission enable gates serial output and fetching
// - stay awake keeps running in global powerdown
// - interrupt enables reset to zero
// - read-only timestamp of last buffer sample
// - cycle counter matches processor cycle count
// - timestamp counter never powers down
// - block powerdown input powers the unit down
// - powerdown freezes serial pins, master clock runs
// - 64-byte prefetch plus one holding register
// - empty prefetch at sample time: bandwidth error, repeat
// - missing buffer: underrun, repeat until acknowledge
// - reset bit resets the audio logic
// - drained buffer flags, continue from other buffer
// - acknowledge drops interrupt next clock edge
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module audio_out_irq_error_timestamp #(
  parameter int BIT_HALF_DIV = 4,
  parameter int MCLK_HALF_DIV = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // power control
  input wire logic global_powerdown,
  input wire logic block_powerdown,
  // memory read port
  output logic dma_req,
  output logic [31:0] dma_addr,
  input wire logic dma_ack,
  input wire logic [31:0] dma_rdata,
  // converter pins
  output logic serial_bit_clock,
  output logic serial_data_outputs,
  output logic word_select,
  output logic converter_master_clock,
  // interrupt
  output logic audio_out_irq
);
  localparam int DEPTH = audio_out_pkg::PREFETCH_WORDS;
  localparam int LW = $clog2(DEPTH+1);

  if (BIT_HALF_DIV < 1 || BIT_HALF_DIV > 65535 || MCLK_HALF_DIV < 1 || MCLK_HALF_DIV > 65535)
  begin : g_div_check
    $error("clock dividers must lie between 1 and 65535");
  end

  // ==========================================================
  // register decode and control fields
  logic ctl_wr, soft_rst, pd, run;
  logic [3:0] ack;
  logic trans_en_ff, awake_ff, nxt_trans_en, nxt_awake;
  logic [3:0] inten_ff, nxt_inten;
  logic [31:0] base1_ff, base2_ff, nxt_base1, nxt_base2;
  logic [15:0] size_ff, nxt_size;

  assign ctl_wr = reg_write && reg_addr == audio_out_pkg::CONTROL_OFFSET;
  assign soft_rst = ctl_wr && reg_wdata[audio_out_pkg::CTL_RESET_BIT];
  assign ack = ctl_wr ? reg_wdata[audio_out_pkg::CTL_ACK_LSB +: 4] : 4'h0;
  assign pd = block_powerdown || (global_powerdown && !awake_ff);
  assign run = trans_en_ff && !pd;

  always_comb begin
    nxt_trans_en = trans_en_ff;
    nxt_awake = awake_ff;
    nxt_inten = inten_ff;
    nxt_base1 = base1_ff;
    nxt_base2 = base2_ff;
    nxt_size = size_ff;
    if (ctl_wr) begin
      nxt_trans_en = reg_wdata[audio_out_pkg::CTL_TRANS_BIT];
      nxt_awake = reg_wdata[audio_out_pkg::CTL_AWAKE_BIT];
      nxt_inten = reg_wdata[audio_out_pkg::CTL_INTEN_LSB +: 4];
    end
    if (reg_write && reg_addr == audio_out_pkg::BASE1_OFFSET) begin
      nxt_base1 = reg_wdata;
    end
    if (reg_write && reg_addr == audio_out_pkg::BASE2_OFFSET) begin
      nxt_base2 = reg_wdata;
    end
    if (reg_write && reg_addr == audio_out_pkg::SIZE_OFFSET) begin
      nxt_size = reg_wdata[15:0];
    end
    if (soft_rst) begin
      nxt_trans_en = 1'b0;
      nxt_awake = 1'b0;
      nxt_inten = audio_out_pkg::INTEN_RESET;
      nxt_base1 = audio_out_pkg::BASE_RESET;
      nxt_base2 = audio_out_pkg::BASE_RESET;
      nxt_size = audio_out_pkg::SIZE_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trans_en_ff <= 1'b0;
      awake_ff <= 1'b0;
      inten_ff <= audio_out_pkg::INTEN_RESET;
      base1_ff <= audio_out_pkg::BASE_RESET;
      base2_ff <= audio_out_pkg::BASE_RESET;
      size_ff <= audio_out_pkg::SIZE_RESET;
    end else begin
      trans_en_ff <= nxt_trans_en;
      awake_ff <= nxt_awake;
      inten_ff <= nxt_inten;
      base1_ff <= nxt_base1;
      base2_ff <= nxt_base2;
      size_ff <= nxt_size;
    end
  end

  // ==========================================================
  // condition flags and interrupt
  logic [3:0] flags_ff, nxt_flags, flag_set;
  logic [3:0] fetch_set, serial_set;

  // each process drives its own event vector; one net merges them
  assign flag_set = fetch_set | serial_set;

  always_comb begin
    nxt_flags = (flags_ff & ~ack) | flag_set;
    if (soft_rst) begin
      nxt_flags = audio_out_pkg::FLAGS_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= audio_out_pkg::FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign audio_out_irq = |(flags_ff & inten_ff);

  // ==========================================================
  // buffer fetch into the prefetch store
  audio_out_pkg::fetch_state_t fetch_ff, nxt_fetch;
  logic [1:0] valid_ff, nxt_valid;
  logic active_ff, nxt_active;
  logic [15:0] idx_ff, nxt_idx;
  logic [31:0] addr_ff, nxt_addr;
  logic cur_valid, word_last, push, in_ready, out_valid, pop;
  logic [31:0] cur_base;
  logic [32:0] out_word;
  logic [LW-1:0] level;

  assign cur_valid = active_ff ? valid_ff[0] : valid_ff[1];
  assign cur_base = active_ff ? base1_ff : base2_ff;
  assign word_last = ({1'b0, idx_ff} + 17'h00001) >= {1'b0, size_ff};
  assign push = fetch_ff == audio_out_pkg::FETCH_WAIT && dma_ack && in_ready;
  assign dma_req = fetch_ff == audio_out_pkg::FETCH_WAIT;
  assign dma_addr = addr_ff;

  always_comb begin
    nxt_fetch = fetch_ff;
    nxt_valid = valid_ff;
    nxt_active = active_ff;
    nxt_idx = idx_ff;
    nxt_addr = addr_ff;
    fetch_set = 4'h0;
    unique case (fetch_ff)
      audio_out_pkg::FETCH_IDLE: begin
        if (run && cur_valid && level != LW'(DEPTH)) begin
          nxt_fetch = audio_out_pkg::FETCH_WAIT;
          nxt_addr = cur_base + {14'h0000, idx_ff, 2'h0};
        end
      end
      audio_out_pkg::FETCH_WAIT: begin
        if (push) begin
          nxt_fetch = audio_out_pkg::FETCH_IDLE;
          nxt_idx = idx_ff + 16'h0001;
          if (word_last) begin
            fetch_set[audio_out_pkg::FLAG_FIRST] = active_ff;
            fetch_set[audio_out_pkg::FLAG_SECOND] = !active_ff;
            nxt_valid[0] = active_ff ? 1'b0 : valid_ff[0];
            nxt_valid[1] = active_ff ? valid_ff[1] : 1'b0;
            nxt_active = !active_ff;
            nxt_idx = 16'h0000;
          end
        end
      end
    endcase
    // a first or second acknowledge hands over a refilled buffer and ends an underrun
    if (ack[audio_out_pkg::FLAG_FIRST]) begin
      nxt_valid[0] = 1'b1;
    end
    if (ack[audio_out_pkg::FLAG_SECOND]) begin
      nxt_valid[1] = 1'b1;
    end
    if (soft_rst) begin
      nxt_fetch = audio_out_pkg::FETCH_IDLE;
      nxt_valid = audio_out_pkg::BUF_VALID_RESET;
      nxt_active = 1'b1;
      nxt_idx = 16'h0000;
      nxt_addr = 32'h00000000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_ff <= audio_out_pkg::FETCH_IDLE;
      valid_ff <= audio_out_pkg::BUF_VALID_RESET;
      active_ff <= 1'b1;
      idx_ff <= 16'h0000;
      addr_ff <= 32'h00000000;
    end else begin
      fetch_ff <= nxt_fetch;
      valid_ff <= nxt_valid;
      active_ff <= nxt_active;
      idx_ff <= nxt_idx;
      addr_ff <= nxt_addr;
    end
  end

  audio_out_prefetch #(
    .WIDTH(33),
    .DEPTH(DEPTH)
  ) u_prefetch (
    .clk(clk),
    .rst(rst),
    .flush(soft_rst),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({word_last, dma_rdata}),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_word),
    .level(level)
  );

  // ==========================================================
  // holding register and serial output
  logic [31:0] hold_ff, last_ff, shift_ff, nxt_hold, nxt_last, nxt_shift, word;
  logic hold_full_ff, hold_last_ff, shift_last_ff, primed_ff;
  logic nxt_hold_full, nxt_hold_last, nxt_shift_last, nxt_primed;
  logic [15:0] half_cnt_ff, nxt_half_cnt;
  logic sck_ff, sd_ff, ws_ff, nxt_sck, nxt_sd, nxt_ws;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic half_tick, fall, sample_due, ts_capture;

  assign pop = out_valid && !hold_full_ff;
  assign half_tick = run && half_cnt_ff == 16'(BIT_HALF_DIV - 1);
  assign fall = half_tick && sck_ff;
  assign sample_due = fall && bit_cnt_ff == 5'h00;
  assign ts_capture = sample_due && shift_last_ff;

  always_comb begin
    nxt_hold = hold_ff;
    nxt_hold_full = hold_full_ff;
    nxt_hold_last = hold_last_ff;
    nxt_last = last_ff;
    nxt_shift = shift_ff;
    nxt_shift_last = shift_last_ff;
    nxt_primed = primed_ff;
    nxt_half_cnt = half_cnt_ff;
    nxt_sck = sck_ff;
    nxt_sd = sd_ff;
    nxt_ws = ws_ff;
    nxt_bit_cnt = bit_cnt_ff;
    word = hold_full_ff ? hold_ff : last_ff;
    serial_set = 4'h0;
    if (pop) begin
      nxt_hold = out_word[31:0];
      nxt_hold_last = out_word[32];
      nxt_hold_full = 1'b1;
    end
    if (run) begin
      nxt_half_cnt = half_tick ? 16'h0000 : half_cnt_ff + 16'h0001;
    end
    if (half_tick) begin
      nxt_sck = !sck_ff;
    end
    if (fall) begin
      nxt_ws = bit_cnt_ff[4];
      nxt_bit_cnt = bit_cnt_ff + 5'h01;
      nxt_sd = shift_ff[31];
      nxt_shift = {shift_ff[30:0], 1'b0};
    end
    if (sample_due) begin
      nxt_sd = word[31];
      nxt_shift = {word[30:0], 1'b0};
      nxt_last = word;
      nxt_shift_last = hold_full_ff && hold_last_ff;
      if (hold_full_ff) begin
        nxt_hold_full = 1'b0;
        nxt_primed = 1'b1;
      end else if (primed_ff) begin
        // starved with no buffer handed over is underrun, otherwise fetch was too slow
        serial_set[audio_out_pkg::FLAG_STARVED] = !cur_valid;
        serial_set[audio_out_pkg::FLAG_BANDWIDTH] = cur_valid;
      end
    end
    if (soft_rst) begin
      nxt_hold_full = 1'b0;
      nxt_hold_last = 1'b0;
      nxt_last = 32'h00000000;
      nxt_shift = 32'h00000000;
      nxt_shift_last = 1'b0;
      nxt_primed = 1'b0;
      nxt_half_cnt = 16'h0000;
      nxt_sck = 1'b0;
      nxt_sd = 1'b0;
      nxt_ws = 1'b0;
      nxt_bit_cnt = 5'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff <= 32'h00000000;
      hold_full_ff <= 1'b0;
      hold_last_ff <= 1'b0;
      last_ff <= 32'h00000000;
      shift_ff <= 32'h00000000;
      shift_last_ff <= 1'b0;
      primed_ff <= 1'b0;
      half_cnt_ff <= 16'h0000;
      sck_ff <= 1'b0;
      sd_ff <= 1'b0;
      ws_ff <= 1'b0;
      bit_cnt_ff <= 5'h00;
    end else begin
      hold_ff <= nxt_hold;
      hold_full_ff <= nxt_hold_full;
      hold_last_ff <= nxt_hold_last;
      last_ff <= nxt_last;
      shift_ff <= nxt_shift;
      shift_last_ff <= nxt_shift_last;
      primed_ff <= nxt_primed;
      half_cnt_ff <= nxt_half_cnt;
      sck_ff <= nxt_sck;
      sd_ff <= nxt_sd;
      ws_ff <= nxt_ws;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  assign serial_bit_clock = sck_ff;
  assign serial_data_outputs = sd_ff;
  assign word_select = ws_ff;

  // ==========================================================
  // timestamp, master clock and read data
  logic [31:0] ts_cnt_ff, ts_ff, nxt_ts_cnt, nxt_ts, rdata_ff, nxt_rdata;
  logic [15:0] mclk_cnt_ff, nxt_mclk_cnt;
  logic mclk_ff, nxt_mclk;

  always_comb begin
    nxt_ts_cnt = ts_cnt_ff + 32'h00000001;
    nxt_ts = ts_capture ? ts_cnt_ff : ts_ff;
    if (soft_rst) begin
      nxt_ts = audio_out_pkg::TIMESTAMP_RESET;
    end
    nxt_mclk_cnt = mclk_cnt_ff + 16'h0001;
    nxt_mclk = mclk_ff;
    if (mclk_cnt_ff == 16'(MCLK_HALF_DIV - 1)) begin
      nxt_mclk_cnt = 16'h0000;
      nxt_mclk = !mclk_ff;
    end
    nxt_rdata = 32'h00000000;
    if (reg_read) begin
      unique case (reg_addr)
        audio_out_pkg::CONTROL_OFFSET: nxt_rdata = {1'b0, trans_en_ff, awake_ff, 21'h000000,
                                                    inten_ff, 4'h0};
        audio_out_pkg::TIMESTAMP_OFFSET: nxt_rdata = ts_ff;
        audio_out_pkg::STATUS_OFFSET: nxt_rdata = {27'h0000000, active_ff, flags_ff};
        audio_out_pkg::BASE1_OFFSET: nxt_rdata = base1_ff;
        audio_out_pkg::BASE2_OFFSET: nxt_rdata = base2_ff;
        audio_out_pkg::SIZE_OFFSET: nxt_rdata = {16'h0000, size_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_cnt_ff <= audio_out_pkg::TIMESTAMP_RESET;
      ts_ff <= audio_out_pkg::TIMESTAMP_RESET;
      mclk_cnt_ff <= 16'h0000;
      mclk_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ts_cnt_ff <= nxt_ts_cnt;
      ts_ff <= nxt_ts;
      mclk_cnt_ff <= nxt_mclk_cnt;
      mclk_ff <= nxt_mclk;
      rdata_ff <= nxt_rdata;
    end
  end

  assign converter_master_clock = mclk_ff;
  assign reg_rdata = rdata_ff;

  // ==========================================================
  // assertions
  sequence s_ack_first;
    ctl_wr && reg_wdata[audio_out_pkg::FLAG_FIRST] && !flag_set[audio_out_pkg::FLAG_FIRST];
  endsequence
  sequence s_ack_second;
    ctl_wr && reg_wdata[audio_out_pkg::FLAG_SECOND] && !flag_set[audio_out_pkg::FLAG_SECOND];
  endsequence
  sequence s_ctl_read;
    reg_read && reg_addr == audio_out_pkg::CONTROL_OFFSET;
  endsequence

  a_irq_from_flag: assert property (@(posedge clk) disable iff (rst)
    (flags_ff[audio_out_pkg::FLAG_BANDWIDTH] && inten_ff[audio_out_pkg::FLAG_BANDWIDTH])
    |-> audio_out_irq) else $error("enabled flag without interrupt");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (flags_ff != 4'h0 && !ctl_wr) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag cleared without acknowledge");
  a_first_ack_clears: assert property (@(posedge clk) disable iff (rst)
    s_ack_first |=> !flags_ff[audio_out_pkg::FLAG_FIRST])
    else $error("first acknowledge did not clear");
  a_second_ack_clears: assert property (@(posedge clk) disable iff (rst)
    s_ack_second |=> !flags_ff[audio_out_pkg::FLAG_SECOND])
    else $error("second acknowledge did not clear");
  a_ack_read_zero: assert property (@(posedge clk) disable iff (rst)
    s_ctl_read |=> reg_rdata[3:0] == 4'h0) else $error("acknowledge bits read nonzero");
  a_starved_kept: assert property (@(posedge clk) disable iff (rst)
    (flags_ff[audio_out_pkg::FLAG_STARVED] && !soft_rst
     && !(ctl_wr && reg_wdata[audio_out_pkg::FLAG_STARVED]))
    |=> flags_ff[audio_out_pkg::FLAG_STARVED]) else $error("underrun lost");
  a_idle_no_fetch: assert property (@(posedge clk) disable iff (rst)
    (!trans_en_ff && fetch_ff == audio_out_pkg::FETCH_IDLE) |=> !dma_req)
    else $error("fetch while disabled");
  a_pd_freeze: assert property (@(posedge clk) disable iff (rst)
    (pd && !soft_rst) |=> $stable(serial_bit_clock) && $stable(serial_data_outputs)
    && $stable(word_select)) else $error("serial pins moved in powerdown");
  a_ts_counts: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ts_cnt_ff == $past(ts_cnt_ff) + 32'h00000001) else $error("cycle counter stalled");
  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    (flag_set != 4'h0 && !soft_rst) |=> (flags_ff & $past(flag_set)) == $past(flag_set))
    else $error("flag event lost");
  a_repeat_on_starve: assert property (@(posedge clk) disable iff (rst)
    (sample_due && !hold_full_ff && !soft_rst) |=> last_ff == $past(last_ff))
    else $error("starved sample not repeated");
endmodule // audio_out_irq_error_timestamp
`default_nettype wire

// ---- mem_model.sv ----
// memory responder for the audio output fetch port
// assumes at most one word outstanding, as the fetch side promises
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fetch port
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  output logic dma_ack,
  output logic [31:0] dma_rdata,
  // answer delay in cycles
  input wire logic [8:0] lat
);
  logic [8:0] cnt;
  // answers after lat cycles; data churns outside the ack cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 9'h000;
      dma_ack <= 1'b0;
      dma_rdata <= 32'h0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req && !dma_ack && cnt >= lat) begin
        dma_ack <= 1'b1;
        dma_rdata <= {~dma_addr[15:0], dma_addr[15:0]};
        cnt <= 9'h000;
      end else if (dma_req && !dma_ack) begin
        cnt <= cnt + 9'h001;
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the audio output status block
// assumes the memory responder and the design files compile first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic global_powerdown = 1'b0;
  logic block_powerdown = 1'b0;
  logic [8:0] lat = 9'h002;
  logic [31:0] reg_rdata, dma_addr, dma_rdata, d;
  logic dma_req, dma_ack, serial_bit_clock, serial_data_outputs, word_select;
  logic converter_master_clock, audio_out_irq;
  int n_errors = 0;
  int n_tests = 0;
  logic sck_q = 1'b0;
  logic ws_q = 1'b0;
  logic [31:0] ser = 32'h0;
  logic [31:0] word_seen = 32'h0;

  always #10 clk = ~clk;

  // collects bits at bit clock rises; a word is complete when word select falls
  always @(negedge clk) begin
    sck_q <= serial_bit_clock;
    if (serial_bit_clock && !sck_q) begin
      ser <= {ser[30:0], serial_data_outputs};
      ws_q <= word_select;
      if (!word_select && ws_q) begin
        word_seen <= ser;
      end
    end
  end

  audio_out_irq_error_timestamp #(.BIT_HALF_DIV(1), .MCLK_HALF_DIV(1))
    u_audio_out_irq_error_timestamp (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .global_powerdown, .block_powerdown, .dma_req, .dma_addr, .dma_ack, .dma_rdata,
    .serial_bit_clock, .serial_data_outputs, .word_select, .converter_master_clock,
    .audio_out_irq
  );
  mem_model u_mem_model (.clk, .rst, .dma_req, .dma_addr, .dma_ack, .dma_rdata, .lat);

  // ==========================================
  // access and check tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, x);
  endtask
  task automatic ci(input logic x);
    chk("irq", {31'h0, audio_out_irq}, {31'h0, x});
  endtask
  // watches pins for 40 cycles: frozen or moving, master clock always moving
  task automatic pd(input logic frz);
    logic [2:0] p;
    logic m;
    int nc, mc;
    nc = 0;
    mc = 0;
    repeat (3) @(posedge clk);
    #1 p = {serial_bit_clock, serial_data_outputs, word_select};
    m = converter_master_clock;
    repeat (40) begin
      @(posedge clk);
      #1 if ({serial_bit_clock, serial_data_outputs, word_select} !== p) nc++;
      if (converter_master_clock !== m) mc++;
      m = converter_master_clock;
    end
    chk("pins moving", {31'h0, nc > 0}, {31'h0, !frz});
    chk("master clock", {31'h0, mc > 0}, 32'h1);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(8'h00, 32'h0, "control");
    rc(8'h08, 32'h10, "status");
    rc(8'h04, 32'h0, "timestamp");
    rc(8'h20, 32'h0, "unmapped");
    wr(8'h00, 32'h0000000F);
    rc(8'h00, 32'h0, "ack bits");
    ci(1'b0);
    $display("reset test done");
    wr(8'h0C, 32'h40);
    wr(8'h10, 32'h80);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h400000F0);
    repeat (400) @(posedge clk);
    rc(8'h08, 32'h1B, "drained");
    chk("repeated word", word_seen, 32'hFF7F0080);
    ci(1'b1);
    wr(8'h00, 32'h40000020);
    ci(1'b1);
    wr(8'h00, 32'h40000022);
    ci(1'b0);
    rc(8'h08, 32'h19, "ack second");
    wr(8'h00, 32'h40000088);
    ci(1'b0);
    rc(8'h08, 32'h11, "ack starved");
    $display("flag test done");
    @(posedge clk) lat <= 9'h12C;
    wr(8'h00, 32'h40000043);
    repeat (150) @(posedge clk);
    ci(1'b1);
    @(posedge clk) lat <= 9'h001;
    repeat (20) @(posedge clk);
    rd(8'h08, d);
    chk("bandwidth", d & 32'h4, 32'h4);
    wr(8'h00, 32'h40000044);
    ci(1'b0);
    rd(8'h08, d);
    chk("bandwidth ack", d & 32'h4, 32'h0);
    $display("error test done");
    @(posedge clk) block_powerdown <= 1'b1;
    pd(1'b1);
    @(posedge clk) block_powerdown <= 1'b0;
    global_powerdown <= 1'b1;
    pd(1'b1);
    wr(8'h00, 32'h60000000);
    pd(1'b0);
    @(posedge clk) global_powerdown <= 1'b0;
    wr(8'h00, 32'h0);
    pd(1'b1);
    $display("power test done");
    rd(8'h04, d);
    chk("stamp set", {31'h0, d != 32'h0}, 32'h1);
    wr(8'h04, 32'h0);
    rc(8'h04, d, "stamp read only");
    wr(8'h00, 32'hE00000F0);
    rc(8'h00, 32'h0, "soft reset");
    rc(8'h08, 32'h10, "reset status");
    rc(8'h04, 32'h0, "reset stamp");
    $display("stamp test done");
    close_out();
  end

  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
